//--- shared/rilc_pkg.sv
/*
 * Constants, register layout and state encoding for the reset, pin
 * interrupt and low-voltage control block.
 * Assumes a 40 MHz bus clock and an 8-bit register port.
 */
`default_nettype none

package rilc_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int RST_MIN_NS    = 100;
	localparam int RST_MIN_CYC   =
		(RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RST_MIN_CNT = 4'(RST_MIN_CYC);

	// Register offsets
	localparam logic [7:0] OFS_PIN = 8'h00;
	localparam logic [7:0] OFS_RST = 8'h01;
	localparam logic [7:0] OFS_PWR = 8'h02;

	// Pin interrupt status and control fields
	localparam int PIN_PDD  = 6;
	localparam int PIN_POL  = 5;
	localparam int PIN_PE   = 4;
	localparam int PIN_FLAG = 3;
	localparam int PIN_ACK  = 2;
	localparam int PIN_IE   = 1;
	localparam int PIN_MOD  = 0;
	localparam logic [7:0] PIN_RW_MASK = 8'h73;
	localparam logic [7:0] PIN_RST_VAL = 8'h00;

	// Reset source status fields
	localparam int ST_POR  = 7;
	localparam int ST_PIN  = 6;
	localparam int ST_WDOG = 5;
	localparam int ST_ILLEGAL_OPCODE_FLAG = 4;
	localparam int ST_LOC  = 2;
	localparam int ST_LVD  = 1;
	localparam logic [7:0] ST_POR_VAL  = 8'h82;
	localparam logic [7:0] ST_POR_MASK = 8'h80;

	// Power management control fields
	localparam int PWR_WFLAG = 7;
	localparam int PWR_WACK  = 6;
	localparam int PWR_WIE   = 5;
	localparam int PWR_RE    = 4;
	localparam int PWR_SE    = 3;
	localparam int PWR_DE    = 2;
	localparam int PWR_THR   = 0;
	localparam logic [7:0] PWR_RW_MASK = 8'h3d;
	localparam logic [7:0] PWR_RST_VAL = 8'h1c;

	// Watchdog service keys
	localparam logic [7:0] WDOG_KEY1 = 8'h55;
	localparam logic [7:0] WDOG_KEY2 = 8'haa;

	// Synchroniser lanes and their idle levels
	localparam int SYN_RSTPIN = 0;
	localparam int SYN_IRQ    = 1;
	localparam int SYN_TRIP   = 2;
	localparam int SYN_WARN   = 3;
	localparam logic [3:0] SYN_IDLE = 4'h3;

	typedef enum logic [1:0] {
		RILC_RUN = 2'b01,
		RILC_RST = 2'b10
	} rilc_state_e;

endpackage

`default_nettype wire

//--- hdl/rilc_ctrl.sv
/*
 * Reset sequencing with reset-source status, external interrupt pin
 * detection, low-voltage detect control and watchdog service checking.
 * Assumes same-clock reset sources from core and watchdog, asynchronous
 * pin and supply detector inputs, and rstn as the power-on reset.
 */
// Notes on behaviour
// - Detector enabled only while detect enable set
// - Stop mode disables detector unless stop enable
// - Both enables turn deep stop into shallow stop
// - Power-on sets power-on and low-voltage flags
// - Low voltage resets only when reset enabled
// - Low-voltage reset held until supply recovers
// - Warning sets flag, interrupt when enabled
// - Pull disable bit switches pin pull off
// - Polarity bit picks falling/low or rising/high
// - Rising polarity turns pullup into pulldown
// - Enable bit turns pin function on
// - Read-only event flag set by pin events
// - Acknowledge bit clears flag, reads zero
// - Level mode: acknowledge ignored while asserted
// - Interrupt enable requests while event flag set
// - Mode bit: edges only or edges plus levels
// - Status register holds last reset causes
// - Debug forced reset leaves status flags clear
// - Any status write restarts watchdog count
// - Service needs 55 then aa, else reset
// - Active sources set flags, others cleared; low-voltage reset keeps power-on flag
// - Reset pin low sets pin reset flag
`timescale 1ns/10ps
`default_nettype none

module rilc_ctrl (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// External interrupt pin
	input  wire logic       irq_pin_in,
	output logic            pull_up_en,
	output logic            pull_dn_en,
	output logic            pin_irq,
	// Supply detectors
	input  wire logic       lvd_trip,
	input  wire logic       lvw_trip,
	output logic            lvd_enable,
	output logic            lvd_threshold,
	output logic            lvw_irq,
	// Stop mode
	input  wire logic       stop_active,
	input  wire logic       stop_deep_req,
	output logic            stop_deep_grant,
	// Reset sources and reset output
	input  wire logic       reset_pin_n,
	input  wire logic       wdog_timeout,
	input  wire logic       illegal_opcode,
	input  wire logic       clock_loss,
	input  wire logic       debug_force,
	output logic            sys_reset,
	output logic            wdog_restart
);

	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] o);
		addr_hit = (a == o);
	endfunction

	function automatic logic [7:0] mk_flags(input logic pn,
		input logic wd, input logic il, input logic lc, input logic lv);
		logic [7:0] f;
		f = 8'h00;
		f[rilc_pkg::ST_PIN]  = pn;
		f[rilc_pkg::ST_WDOG] = wd;
		f[rilc_pkg::ST_ILLEGAL_OPCODE_FLAG] = il;
		f[rilc_pkg::ST_LOC]  = lc;
		f[rilc_pkg::ST_LVD]  = lv;
		mk_flags = f;
	endfunction

	// Synchronisers
	logic [3:0] syn1;
	logic [3:0] syn2;
	logic [3:0] syn3;
	logic [3:0] stab;
	wire  [3:0] raw_in;
	wire  [3:0] agree;

	assign raw_in = {lvw_trip, lvd_trip, irq_pin_in, reset_pin_n};
	assign agree  = ~(syn2 ^ syn3);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			syn1 <= rilc_pkg::SYN_IDLE;
			syn2 <= rilc_pkg::SYN_IDLE;
			syn3 <= rilc_pkg::SYN_IDLE;
			stab <= rilc_pkg::SYN_IDLE;
		end
		else
		begin
			syn1 <= raw_in;
			syn2 <= syn1;
			syn3 <= syn2;
			stab <= (stab & ~agree) | (syn3 & agree);
		end
	end

	// State
	rilc_pkg::rilc_state_e state;
	rilc_pkg::rilc_state_e next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] status;
	logic [7:0] next_status;
	logic       lvd_hold;
	logic       next_hold;
	logic [7:0] pin_ctl;
	logic       pin_flag;
	logic       pin_prev;
	logic [7:0] pwr_ctl;
	logic       warn_flag;
	logic       armed;
	logic       seq_bad;
	logic       after_por;

	// Address decode
	wire hit_pin;
	wire hit_rst;
	wire hit_pwr;
	wire wr_pin;
	wire wr_rst;
	wire wr_pwr;

	assign hit_pin = addr_hit(addr, rilc_pkg::OFS_PIN);
	assign hit_rst = addr_hit(addr, rilc_pkg::OFS_RST);
	assign hit_pwr = addr_hit(addr, rilc_pkg::OFS_PWR);
	assign wr_pin  = wr & hit_pin;
	assign wr_rst  = wr & hit_rst;
	assign wr_pwr  = wr & hit_pwr;

	// Control fields
	wire pdd;
	wire pol;
	wire pe;
	wire ie;
	wire mode;
	wire lde;
	wire lse;
	wire lre;
	wire lwie;

	assign pdd  = pin_ctl[rilc_pkg::PIN_PDD];
	assign pol  = pin_ctl[rilc_pkg::PIN_POL];
	assign pe   = pin_ctl[rilc_pkg::PIN_PE];
	assign ie   = pin_ctl[rilc_pkg::PIN_IE];
	assign mode = pin_ctl[rilc_pkg::PIN_MOD];
	assign lde  = pwr_ctl[rilc_pkg::PWR_DE];
	assign lse  = pwr_ctl[rilc_pkg::PWR_SE];
	assign lre  = pwr_ctl[rilc_pkg::PWR_RE];
	assign lwie = pwr_ctl[rilc_pkg::PWR_WIE];

	// Pin event detection
	wire pin_lvl;
	wire pin_asserted;
	wire pin_edge;
	wire pin_set;
	wire pin_ack;
	wire next_pin_flag;
	wire next_pull_up;
	wire next_pull_dn;

	assign pin_lvl      = stab[rilc_pkg::SYN_IRQ];
	assign pin_asserted = pe & (pin_lvl == pol);
	assign pin_edge     = pin_asserted & (pin_prev != pol);
	assign pin_set      = pin_edge | (mode & pin_asserted);
	assign pin_ack      = wr_pin & wdata[rilc_pkg::PIN_ACK];
	// Set wins, so in level mode an asserted level blocks the acknowledge
	assign next_pin_flag = pin_set | (pin_flag & ~pin_ack);
	assign next_pull_up  = pe & ~pdd & ~pol;
	assign next_pull_dn  = pe & ~pdd & pol;

	// Low-voltage detection
	wire next_lvd_en;
	wire lvw_set;
	wire lvw_ack;
	wire next_warn;
	wire lvd_act;
	wire trip;

	assign trip        = stab[rilc_pkg::SYN_TRIP];
	assign next_lvd_en = lde & (~stop_active | lse);
	assign lvw_set     = lvd_enable & stab[rilc_pkg::SYN_WARN];
	assign lvw_ack     = wr_pwr & wdata[rilc_pkg::PWR_WACK];
	assign next_warn   = lvw_set | (warn_flag & ~lvw_ack);
	assign lvd_act     = lvd_enable & lre & trip;

	// Watchdog service sequence
	wire key1_ok;
	wire key2_ok;
	wire next_armed;
	wire next_bad;

	assign key1_ok    = (wdata == rilc_pkg::WDOG_KEY1) & ~armed;
	assign key2_ok    = (wdata == rilc_pkg::WDOG_KEY2) & armed;
	assign next_armed = wr_rst ? key1_ok : armed;
	assign next_bad   = wr_rst & ~key1_ok & ~key2_ok;

	// Reset causes
	wire       src_pin;
	wire       src_wd;
	wire       any_src;
	wire [7:0] cause_flags;

	assign src_pin = ~stab[rilc_pkg::SYN_RSTPIN];
	assign src_wd  = wdog_timeout | seq_bad;
	assign any_src = src_pin | src_wd | illegal_opcode | clock_loss |
		lvd_act | debug_force;
	// Debug force contributes no flag
	assign cause_flags = mk_flags(src_pin, src_wd, illegal_opcode,
		clock_loss, lvd_act);

	always_comb
	begin
		next_state  = state;
		next_cnt    = cnt;
		next_status = status;
		next_hold   = lvd_hold;
		case (state)
			rilc_pkg::RILC_RUN:
			begin
				if (any_src)
				begin
					next_state  = rilc_pkg::RILC_RST;
					next_cnt    = rilc_pkg::RST_MIN_CNT;
					next_hold   = lvd_act;
					// An active low-voltage source keeps the power-on flag, even alongside other sources
					next_status = cause_flags | (lvd_act ?
						(status & rilc_pkg::ST_POR_MASK) : 8'h00);
				end
			end
			rilc_pkg::RILC_RST:
			begin
				next_status = status | cause_flags;
				if (cnt != 4'h0)
					next_cnt = cnt - 4'h1;
				if (lvd_act)
					next_hold = 1'b1;
				else if (!trip)
					next_hold = 1'b0;
				if (cnt == 4'h0 && !any_src && !next_hold)
					next_state = rilc_pkg::RILC_RUN;
			end
			default:
				next_state = rilc_pkg::RILC_RUN;
		endcase
	end

	wire in_rst;
	wire next_in_rst;

	assign in_rst      = (state == rilc_pkg::RILC_RST);
	assign next_in_rst = (next_state == rilc_pkg::RILC_RST);

	// Read data
	wire [7:0] rd_word;

	assign rd_word =
		hit_pin ? (pin_ctl | 8'({7'h00, pin_flag} << rilc_pkg::PIN_FLAG)) :
		hit_rst ? status :
		hit_pwr ? (pwr_ctl |
			8'({7'h00, warn_flag} << rilc_pkg::PWR_WFLAG)) :
		8'h00;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state    <= rilc_pkg::RILC_RUN;
			cnt      <= 4'h0;
			status   <= rilc_pkg::ST_POR_VAL;
			lvd_hold <= 1'b0;
			armed    <= 1'b0;
			seq_bad  <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			status   <= next_status;
			lvd_hold <= next_hold;
			armed    <= next_armed & ~in_rst;
			seq_bad  <= next_bad;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_ctl   <= rilc_pkg::PIN_RST_VAL;
			pin_flag  <= 1'b0;
			pin_prev  <= 1'b1;
			pwr_ctl   <= rilc_pkg::PWR_RST_VAL;
			warn_flag <= 1'b0;
		end
		else if (in_rst)
		begin
			pin_ctl   <= rilc_pkg::PIN_RST_VAL;
			pin_flag  <= 1'b0;
			pin_prev  <= pin_lvl;
			warn_flag <= 1'b0;
		end
		else
		begin
			if (wr_pin)
				pin_ctl <= wdata & rilc_pkg::PIN_RW_MASK;
			if (wr_pwr)
				pwr_ctl <= wdata & rilc_pkg::PWR_RW_MASK;
			pin_flag  <= next_pin_flag;
			pin_prev  <= pin_lvl;
			warn_flag <= next_warn;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata           <= 8'h00;
			pull_up_en      <= 1'b0;
			pull_dn_en      <= 1'b0;
			pin_irq         <= 1'b0;
			lvd_enable      <= 1'b0;
			lvd_threshold   <= 1'b0;
			lvw_irq         <= 1'b0;
			stop_deep_grant <= 1'b0;
			sys_reset       <= 1'b1;
			wdog_restart    <= 1'b0;
			after_por       <= 1'b1;
		end
		else
		begin
			rdata           <= rd ? rd_word : 8'h00;
			pull_up_en      <= next_pull_up;
			pull_dn_en      <= next_pull_dn;
			pin_irq         <= next_pin_flag & ie & ~in_rst;
			lvd_enable      <= next_lvd_en;
			lvd_threshold   <= pwr_ctl[rilc_pkg::PWR_THR];
			lvw_irq         <= next_warn & lwie & ~in_rst;
			stop_deep_grant <= stop_deep_req & ~(lde & lse);
			sys_reset       <= next_in_rst;
			wdog_restart    <= wr_rst;
			after_por       <= 1'b0;
		end
	end

	// Assertions
	property p_stop_lvd;
		@(posedge clk) disable iff (!rstn)
		(stop_active && !lse) |=> !lvd_enable;
	endproperty
	a_stop_lvd: assert property (p_stop_lvd)
		else $error("detector left on in stop");

	property p_deep_block;
		@(posedge clk) disable iff (!rstn)
		(stop_deep_req && lde && lse) |=> !stop_deep_grant;
	endproperty
	a_deep_block: assert property (p_deep_block)
		else $error("deep stop granted with detector on");

	property p_por_flags;
		@(posedge clk) disable iff (!rstn)
		after_por |-> (status[rilc_pkg::ST_POR] && status[rilc_pkg::ST_LVD]);
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on flags missing");

	property p_lvd_hold;
		@(posedge clk) disable iff (!rstn)
		(in_rst && lvd_hold && trip) |=> sys_reset;
	endproperty
	a_lvd_hold: assert property (p_lvd_hold)
		else $error("reset released while supply low");

	property p_pulldown;
		@(posedge clk) disable iff (!rstn)
		(pe && !pdd && pol) |=> (pull_dn_en && !pull_up_en);
	endproperty
	a_pulldown: assert property (p_pulldown)
		else $error("pulldown not selected");

	property p_edge_flag;
		@(posedge clk) disable iff (!rstn)
		(pin_edge && !in_rst) |=> pin_flag;
	endproperty
	a_edge_flag: assert property (p_edge_flag)
		else $error("pin event not flagged");

	property p_level_ack;
		@(posedge clk) disable iff (!rstn)
		(pin_ack && mode && pin_asserted && !in_rst) |=> pin_flag;
	endproperty
	a_level_ack: assert property (p_level_ack)
		else $error("flag cleared while level asserted");

	property p_bad_key;
		@(posedge clk) disable iff (!rstn)
		(wr_rst && !armed && wdata != rilc_pkg::WDOG_KEY1) |-> ##2 sys_reset;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("bad service write did not reset");

	property p_restart;
		@(posedge clk) disable iff (!rstn)
		wr_rst |=> wdog_restart;
	endproperty
	a_restart: assert property (p_restart)
		else $error("watchdog not restarted");

	property p_debug_clear;
		@(posedge clk) disable iff (!rstn)
		(!in_rst && debug_force && cause_flags == 8'h00) |=> status == 8'h00;
	endproperty
	a_debug_clear: assert property (p_debug_clear)
		else $error("debug reset left flags set");

	c_pin_irq: cover property (@(posedge clk) disable iff (!rstn)
		pin_irq ##1 pin_ack);
	c_key_ok: cover property (@(posedge clk) disable iff (!rstn)
		wr_rst && key2_ok);
	c_lvd_rst: cover property (@(posedge clk) disable iff (!rstn)
		!in_rst && lvd_act);

endmodule

`default_nettype wire

//--- bench/rilc_pin_src.sv
/*
 * Far-side model: interrupt pin source, reset pin and supply detectors.
 * Assumes the bench commands levels right after rising clock edges.
 */
`timescale 1ns/10ps
`default_nettype none

module rilc_pin_src (
	// Clock
	input  wire logic clk,
	// Commands from the bench
	input  wire logic pin_drive,
	input  wire logic pin_level,
	input  wire logic rst_low,
	input  wire logic supply_low,
	input  wire logic supply_warn,
	// From the block
	input  wire logic pull_up_en,
	input  wire logic pull_dn_en,
	input  wire logic lvd_enable,
	// To the block
	output logic      irq_pin_in,
	output logic      reset_pin_n,
	output logic      lvd_trip,
	output logic      lvw_trip
);
	logic float_q = 1'b0;

	// Released pin with no pull wanders every cycle
	always @(posedge clk)
		float_q <= ~irq_pin_in;
	assign irq_pin_in  = pin_drive ? pin_level : pull_up_en ? 1'b1 :
		pull_dn_en ? 1'b0 : float_q;
	// Reset pin has a pullup
	assign reset_pin_n = ~rst_low;
	// Detector reports only while enabled
	assign lvd_trip    = lvd_enable & supply_low;
	assign lvw_trip    = lvd_enable & supply_warn;
endmodule

`default_nettype wire

//--- bench/rilc_ctrl_bench.sv
/*
 * Self-checking bench for the reset, pin interrupt and low-voltage block.
 * Assumes rilc_pkg and the far-side model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module rilc_ctrl_bench;
	localparam logic [7:0] A_PIN = rilc_pkg::OFS_PIN;
	localparam logic [7:0] A_RST = rilc_pkg::OFS_RST;
	localparam logic [7:0] A_PWR = rilc_pkg::OFS_PWR;
	logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
	logic        irq_pin_in, pull_up_en, pull_dn_en, pin_irq, lvd_trip;
	logic        lvw_trip, lvd_enable, lvd_threshold, lvw_irq;
	logic        stop_active = 1'b0, stop_deep_req = 1'b0, stop_deep_grant;
	logic        wdog_timeout = 1'b0, illegal_opcode = 1'b0;
	logic        clock_loss = 1'b0, debug_force = 1'b0, reset_pin_n;
	logic        sys_reset, wdog_restart, pin_drive = 1'b1;
	logic        pin_level = 1'b0, rst_low = 1'b0;
	logic        supply_low = 1'b0, supply_warn = 1'b0;
	logic [31:0] seed = 32'hd045;
	int          error_cnt = 0, checked = 0, cycles = 0, i;
	// Pin event script: config, pin level, expected flag
	logic [7:0]  pc [10] = '{8'h36, 8'h32, 8'h36, 8'h37, 8'h37,
		8'h35, 8'h11, 8'h10, 8'h14, 8'h12};
	logic [0:9]  pl = 10'b0111000110;
	logic [0:9]  pf = 10'b0101101101;
	logic [7:0]  se [5] = '{8'h40, 8'h00, 8'h20, 8'h04, 8'h10};

	rilc_ctrl rilc_ctrl_i (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
		.irq_pin_in, .pull_up_en, .pull_dn_en, .pin_irq, .lvd_trip,
		.lvw_trip, .lvd_enable, .lvd_threshold, .lvw_irq, .stop_active,
		.stop_deep_req, .stop_deep_grant, .reset_pin_n, .wdog_timeout,
		.illegal_opcode, .clock_loss, .debug_force, .sys_reset,
		.wdog_restart);
	rilc_pin_src rilc_pin_src_i (.clk, .pin_drive, .pin_level, .rst_low,
		.supply_low, .supply_warn, .pull_up_en, .pull_dn_en, .lvd_enable,
		.irq_pin_in, .reset_pin_n, .lvd_trip, .lvw_trip);

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			conclude();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic conclude();
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata & m, e & m);
	endtask

	// Waits out one system reset, then reads the status
	task automatic rst_seen(input logic [7:0] e);
		int k;
		for (k = 0; k < 10 && sys_reset !== 1'b1; k++)
			@(negedge clk);
		chk1(sys_reset, 1'b1);
		for (k = 0; k < 200 && sys_reset !== 1'b0; k++)
			@(negedge clk);
		chk1(sys_reset, 1'b0);
		rd_chk(A_RST, e, 8'hff);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		chk1(sys_reset, 1'b0);
		rd_chk(A_RST, rilc_pkg::ST_POR_VAL, 8'hff);
		rd_chk(A_PIN, rilc_pkg::PIN_RST_VAL, 8'hff);
		rd_chk(A_PWR, rilc_pkg::PWR_RST_VAL, 8'hff);
		wr_reg(8'h7e, 8'hff);
		rd_chk(8'h7e, 8'h00, 8'hff);
		// Random pin settings against the pull device
		for (i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			v = seed[7:0];
			wr_reg(A_PIN, v);
			idle(2);
			chk1(pull_up_en, v[4] & !v[6] & !v[5]);
			chk1(pull_dn_en, v[4] & !v[6] & v[5]);
			rd_chk(A_PIN, v & rilc_pkg::PIN_RW_MASK, 8'hf7);
		end
		wr_reg(A_PIN, 8'h00);
		idle(4);
		// Edge, level, acknowledge and polling script
		for (i = 0; i < 10; i++)
		begin
			wr_reg(A_PIN, pc[i]);
			pin_level <= pl[i];
			idle(8);
			rd_chk(A_PIN, {4'h0, pf[i], 3'h0} | (pc[i] & 8'h73), 8'hff);
			chk1(pin_irq, pf[i] & pc[i][1]);
		end
		// Released pin rests at its pull level
		wr_reg(A_PIN, 8'h15);
		pin_drive <= 1'b0;
		idle(8);
		wr_reg(A_PIN, 8'h15);
		idle(2);
		rd_chk(A_PIN, 8'h11, 8'hff);
		wr_reg(A_PIN, 8'h35);
		idle(8);
		wr_reg(A_PIN, 8'h35);
		idle(2);
		rd_chk(A_PIN, 8'h31, 8'hff);
		@(posedge clk);
		pin_drive <= 1'b1;
		// Detector enable and stop-mode handling
		for (i = 0; i < 8; i++)
		begin
			v = {4'h0, i[1], i[0], 1'b0, i[2]};
			wr_reg(A_PWR, v);
			stop_active <= i[2];
			stop_deep_req <= 1'b1;
			idle(3);
			chk1(lvd_enable, i[0] & (!i[2] | i[1]));
			chk1(stop_deep_grant, !(i[0] & i[1]));
			chk1(lvd_threshold, i[2]);
			rd_chk(A_PWR, v, 8'hff);
		end
		@(posedge clk);
		stop_active <= 1'b0;
		// Warning flag with and without its interrupt
		for (i = 0; i < 2; i++)
		begin
			v = {2'b00, i[0], 5'h04};
			wr_reg(A_PWR, v);
			supply_warn <= 1'b1;
			idle(8);
			chk1(lvw_irq, i[0]);
			rd_chk(A_PWR, v | 8'h80, 8'hff);
			@(posedge clk);
			supply_warn <= 1'b0;
			idle(6);
			wr_reg(A_PWR, v | 8'h40);
			idle(1);
			rd_chk(A_PWR, v, 8'hff);
			chk1(lvw_irq, 1'b0);
		end
		// Watchdog service, good then bad
		wr_reg(A_RST, rilc_pkg::WDOG_KEY1);
		@(negedge clk);
		chk1(wdog_restart, 1'b1);
		wr_reg(A_RST, rilc_pkg::WDOG_KEY2);
		idle(6);
		chk1(sys_reset, 1'b0);
		seed = xs(seed);
		v = (seed[7:0] == 8'h55 || seed[7:0] == 8'haa) ? 8'h33 : seed[7:0];
		wr_reg(A_RST, v);
		@(negedge clk);
		chk1(wdog_restart, 1'b1);
		rst_seen(8'h20);
		// Each reset source alone
		for (i = 0; i < 5; i++)
		begin
			wr_reg(A_PIN, 8'h13);
			@(posedge clk);
			{illegal_opcode, clock_loss, wdog_timeout, debug_force,
				rst_low} <= 5'(1 << i);
			repeat (8) @(posedge clk);
			{illegal_opcode, clock_loss, wdog_timeout, debug_force,
				rst_low} <= 5'h00;
			rst_seen(se[i]);
			rd_chk(A_PIN, 8'h00, 8'hff);
		end
		// Low-voltage reset off, then on and held
		wr_reg(A_PWR, 8'h0c);
		supply_low <= 1'b1;
		idle(20);
		chk1(sys_reset, 1'b0);
		wr_reg(A_PWR, 8'h1c);
		idle(20);
		chk1(sys_reset, 1'b1);
		@(posedge clk);
		supply_low <= 1'b0;
		rst_seen(8'h02);
		// Second power-on, then low voltage keeps the power-on flag
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		chk1(sys_reset, 1'b0);
		@(posedge clk);
		supply_low <= 1'b1;
		idle(12);
		chk1(sys_reset, 1'b1);
		@(posedge clk);
		supply_low <= 1'b0;
		rst_seen(8'h82);
		conclude();
	end
endmodule

`default_nettype wire
